/* hdl/ssb_slave.sv */
// Handshake SPI slave top: synchronisers, slot sequencer and busy line
module ssb_slave (
	input  wire logic       i_sys_clk,
	input  wire logic       i_sys_rst,
	input  wire logic       i_slave_serial_clock_in,
	input  wire logic       i_select_sense_pin_n,
	input  wire logic       i_slave_serial_data_in,
	output logic            o_slave_serial_data_out,
	output logic            o_slave_serial_data_out_oe_n,
	output logic            o_busy_handshake_pin,
	output logic            o_busy_handshake_pin_oe_n,
	input  wire logic [5:0] i_char_limit,
	input  wire logic [5:0] i_tx_count,
	input  wire logic [5:0] i_rx_space,
	input  wire logic [7:0] i_tx_data,
	input  wire logic       i_tx_valid,
	output logic            o_tx_take,
	output logic [7:0]      o_rx_data,
	output logic            o_rx_valid,
	output logic [1:0]      o_slot_op,
	output logic            o_slot_done
);
	// Crossing from the pin and the link domain
	logic       cs_meta;
	logic       cs_sync;
	logic       tg_meta;
	logic       tg_sync;
	logic       tg_prev;
	logic       selected;
	logic       rx_evt;
	logic [7:0] rx_word;
	logic       rx_toggle;
	logic [5:0] eff_limit;

	// Sequencer state and next values
	ssb_pkg::ssb_state_t state;
	ssb_pkg::ssb_state_t next_state;
	ssb_pkg::ssb_op_t    op;
	ssb_pkg::ssb_op_t    next_op;
	logic [5:0]          remain;
	logic [5:0]          next_remain;
	logic [7:0]          tx_word;
	logic [7:0]          next_tx_word;
	logic                next_busy_oe_n;
	logic                next_sdo_oe_n;
	logic [7:0]          next_rx_data;
	logic                next_rx_valid;
	logic                next_tx_take;
	logic                next_slot_done;

	// Cap a character count at the configured limit
	function automatic logic [5:0] cap_count(
		input logic [5:0] n,
		input logic [5:0] lim
	);
		return (n > lim) ? lim : n;
	endfunction

	// Opcodes in which the slave supplies characters
	function automatic logic op_sends(input ssb_pkg::ssb_op_t o);
		return (o == ssb_pkg::OP_MRX) || (o == ssb_pkg::OP_BOTH);
	endfunction

	// Opcodes in which the slave captures characters
	function automatic logic op_takes(input ssb_pkg::ssb_op_t o);
		return (o == ssb_pkg::OP_MTX) || (o == ssb_pkg::OP_BOTH);
	endfunction

	// Status reply: sendable count wins, otherwise free space
	function automatic logic [7:0] status_byte(
		input logic [5:0] txc,
		input logic [5:0] rxs,
		input logic [5:0] lim
	);
		logic [7:0] b;
		if (txc != ssb_pkg::NO_CHARS) begin
			b = {ssb_pkg::STATUS_TAG_SEND, cap_count(txc, lim)};
		end else begin
			b = {ssb_pkg::STATUS_TAG_RECV, cap_count(rxs, lim)};
		end
		return b;
	endfunction

	// Shifter on the master's serial clock
	ssb_link u_link (
		.i_sck       (i_slave_serial_clock_in),
		.i_cs_n      (i_select_sense_pin_n),
		.i_sdi       (i_slave_serial_data_in),
		.i_tx_word   (tx_word),
		.o_sdo       (o_slave_serial_data_out),
		.o_rx_word   (rx_word),
		.o_rx_toggle (rx_toggle)
	);

	// Two-flop synchronisers; the toggle gets a third flop for its edge
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			cs_meta <= 1'h1;
			cs_sync <= 1'h1;
			tg_meta <= 1'h0;
			tg_sync <= 1'h0;
			tg_prev <= 1'h0;
		end else begin
			cs_meta <= i_select_sense_pin_n;
			cs_sync <= cs_meta;
			tg_meta <= rx_toggle;
			tg_sync <= tg_meta;
			tg_prev <= tg_sync;
		end
	end

	// A character spans eight serial clocks, far longer than the sync delay
	assign selected  = ~cs_sync;
	assign rx_evt    = tg_sync ^ tg_prev;
	assign eff_limit = (i_char_limit == ssb_pkg::NO_CHARS) ?
		ssb_pkg::CHAR_LIMIT_DFLT : i_char_limit;

	// Slot sequencer: select, command, decode, data, done
	always_comb begin
		next_state     = state;
		next_op        = op;
		next_remain    = remain;
		next_tx_word   = tx_word;
		next_busy_oe_n = o_busy_handshake_pin_oe_n;
		next_sdo_oe_n  = o_slave_serial_data_out_oe_n;
		next_rx_data   = o_rx_data;
		next_rx_valid  = 1'h0;
		next_tx_take   = 1'h0;
		next_slot_done = 1'h0;
		case (state)
			ssb_pkg::ST_IDLE: begin
				next_busy_oe_n = 1'h1;
				next_sdo_oe_n  = 1'h1;
				if (selected) begin
					// A new slot starts at each selection
					next_sdo_oe_n = 1'h0;
					next_tx_word  = ssb_pkg::FILL_BYTE;
					next_state    = ssb_pkg::ST_PREP;
				end
			end
			ssb_pkg::ST_PREP: begin
				// Fill word is loaded, so the command byte may be clocked
				next_busy_oe_n = 1'h0;
				next_state     = ssb_pkg::ST_CMD;
			end
			ssb_pkg::ST_CMD: begin
				// Master holds off until busy is low
				if (rx_evt) begin
					next_busy_oe_n = 1'h1;
					next_op        = ssb_pkg::ssb_op_t'(rx_word[ssb_pkg::OP_HI:ssb_pkg::OP_LO]);
					next_remain    = cap_count(rx_word[ssb_pkg::CNT_HI:0], eff_limit);
					next_state     = ssb_pkg::ST_DECODE;
				end
			end
			ssb_pkg::ST_DECODE: begin
				// Busy stays high for one cycle only, except on a zero count outside a status command; the master must watch for that pulse
				next_busy_oe_n = 1'h0;
				next_state     = ssb_pkg::ST_DATA;
				if (op == ssb_pkg::OP_STATUS) begin
					next_tx_word = status_byte(i_tx_count, i_rx_space, eff_limit);
					next_remain  = ssb_pkg::ONE_CHAR;
				end else if (remain == ssb_pkg::NO_CHARS) begin
					// Zero count: the slot ends with the command
					next_busy_oe_n = 1'h1;
					next_slot_done = 1'h1;
					next_state     = ssb_pkg::ST_DONE;
				end else if (op_sends(op)) begin
					next_tx_word = i_tx_valid ? i_tx_data : ssb_pkg::FILL_BYTE;
					next_tx_take = i_tx_valid;
				end else begin
					next_tx_word = ssb_pkg::FILL_BYTE;
				end
			end
			ssb_pkg::ST_DATA: begin
				if (rx_evt) begin
					if (op_takes(op)) begin
						next_rx_data  = rx_word;
						next_rx_valid = 1'h1;
					end
					next_remain = remain - ssb_pkg::ONE_CHAR;
					if (remain == ssb_pkg::ONE_CHAR) begin
						next_busy_oe_n = 1'h1;
						next_slot_done = 1'h1;
						next_state     = ssb_pkg::ST_DONE;
					end else if (op_sends(op)) begin
						// Next word must land before the next falling clock edge
						next_tx_word = i_tx_valid ? i_tx_data : ssb_pkg::FILL_BYTE;
						next_tx_take = i_tx_valid;
					end
				end
			end
			ssb_pkg::ST_DONE: begin
				// Further clocks are ignored until deselect
				next_busy_oe_n = 1'h1;
			end
			default: begin
				next_state = ssb_pkg::ST_IDLE;
			end
		endcase
		// Deselect overrides every state
		if (!selected) begin
			next_state     = ssb_pkg::ST_IDLE;
			next_busy_oe_n = 1'h1;
			next_sdo_oe_n  = 1'h1;
		end
	end

	// Sequencer registers
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			state                        <= ssb_pkg::ST_IDLE;
			op                           <= ssb_pkg::OP_STATUS;
			remain                       <= 6'h00;
			tx_word                      <= 8'h00;
			o_busy_handshake_pin_oe_n    <= 1'h1;
			o_slave_serial_data_out_oe_n <= 1'h1;
			o_rx_data                    <= 8'h00;
			o_rx_valid                   <= 1'h0;
			o_tx_take                    <= 1'h0;
			o_slot_done                  <= 1'h0;
		end else begin
			state                        <= next_state;
			op                           <= next_op;
			remain                       <= next_remain;
			tx_word                      <= next_tx_word;
			o_busy_handshake_pin_oe_n    <= next_busy_oe_n;
			o_slave_serial_data_out_oe_n <= next_sdo_oe_n;
			o_rx_data                    <= next_rx_data;
			o_rx_valid                   <= next_rx_valid;
			o_tx_take                    <= next_tx_take;
			o_slot_done                  <= next_slot_done;
		end
	end

	// Open drain: the pin only ever pulls low, the pull-up gives busy
	assign o_busy_handshake_pin = 1'h0;
	assign o_slot_op            = op;

	// Checks below run on the system clock; reset disables them
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_sys_rst);

	chk_reset_quiet: assert property (
		$fell(i_sys_rst) |->
			o_busy_handshake_pin_oe_n && o_slave_serial_data_out_oe_n
	) else $error("driver active right after reset");

	chk_idle_silent: assert property (
		state == ssb_pkg::ST_IDLE |->
			o_busy_handshake_pin_oe_n && o_slave_serial_data_out_oe_n
	) else $error("idle slave drives a pin");

	chk_deselect_off: assert property (
		!selected |=> o_slave_serial_data_out_oe_n &&
			o_busy_handshake_pin_oe_n && state == ssb_pkg::ST_IDLE
	) else $error("deselect did not release the pins");

	chk_busy_after_prep: assert property (
		$fell(o_busy_handshake_pin_oe_n) |->
			$past(state) inside {ssb_pkg::ST_PREP, ssb_pkg::ST_DECODE}
	) else $error("busy went low without preparation");

	chk_ready_in_cmd: assert property (
		state == ssb_pkg::ST_CMD |-> !o_busy_handshake_pin_oe_n
	) else $error("busy high while waiting for command");

	chk_cmd_busy_high: assert property (
		state == ssb_pkg::ST_CMD && rx_evt && selected |=>
			o_busy_handshake_pin_oe_n && state == ssb_pkg::ST_DECODE
	) else $error("busy not raised after command byte");

	chk_data_ready: assert property (
		state == ssb_pkg::ST_DECODE && selected |=>
			(state == ssb_pkg::ST_DATA && !o_busy_handshake_pin_oe_n) ||
			(state == ssb_pkg::ST_DONE && o_busy_handshake_pin_oe_n)
	) else $error("data phase readiness wrong");

	chk_status_tag: assert property (
		state == ssb_pkg::ST_DECODE && op == ssb_pkg::OP_STATUS && selected
		|=> tx_word[ssb_pkg::OP_HI:ssb_pkg::OP_LO] ==
			(($past(i_tx_count) != 6'h00) ? 2'h1 : 2'h0)
	) else $error("status reply tag wrong");

	chk_count_cap: assert property (
		state == ssb_pkg::ST_CMD && rx_evt && selected |=>
			remain <= $past(eff_limit)
	) else $error("character count above limit");

	chk_rx_capture: assert property (
		state == ssb_pkg::ST_DATA && rx_evt && selected && op_takes(op)
		|=> o_rx_valid && o_rx_data == $past(rx_word)
	) else $error("incoming character not delivered");

	chk_tx_supply: assert property (
		state == ssb_pkg::ST_DATA && rx_evt && selected && op_sends(op) &&
		remain != ssb_pkg::ONE_CHAR && i_tx_valid
		|=> o_tx_take && tx_word == $past(i_tx_data)
	) else $error("next outgoing character not loaded");

	chk_slot_end: assert property (
		state == ssb_pkg::ST_DATA && rx_evt && selected &&
		remain == ssb_pkg::ONE_CHAR
		|=> o_busy_handshake_pin_oe_n && o_slot_done ##1 !o_slot_done
	) else $error("slot end not signalled");

	chk_one_command: assert property (
		state == ssb_pkg::ST_DONE |=>
			state inside {ssb_pkg::ST_DONE, ssb_pkg::ST_IDLE}
	) else $error("second command accepted in one slot");

	// The word on the link must not move while the master may be shifting it
	chk_cmd_word_hold: assert property (
		state == ssb_pkg::ST_CMD |=> $stable(tx_word)
	) else $error("outgoing word changed during command byte");

	chk_data_word_hold: assert property (
		state == ssb_pkg::ST_DATA && !rx_evt |=> $stable(tx_word)
	) else $error("outgoing word changed inside a character");

	chk_select_fill: assert property (
		state == ssb_pkg::ST_IDLE && selected |=> state == ssb_pkg::ST_PREP &&
			tx_word == ssb_pkg::FILL_BYTE && !o_slave_serial_data_out_oe_n
	) else $error("selection did not start a slot");

	chk_status_single: assert property (
		state == ssb_pkg::ST_DECODE && op == ssb_pkg::OP_STATUS && selected |=>
			state == ssb_pkg::ST_DATA && remain == ssb_pkg::ONE_CHAR
	) else $error("status reply is not one character");

	chk_zero_count: assert property (
		state == ssb_pkg::ST_DECODE && op != ssb_pkg::OP_STATUS &&
		remain == ssb_pkg::NO_CHARS && selected
		|=> o_slot_done && o_busy_handshake_pin_oe_n && state == ssb_pkg::ST_DONE
	) else $error("empty slot not closed at decode");

	chk_take_single: assert property (
		o_tx_take |=> !o_tx_take
	) else $error("outgoing character taken twice in a row");

	// Main slot scenarios, one per opcode plus a transfer cut by deselect
	cov_status_slot: cover property (o_slot_done && op == ssb_pkg::OP_STATUS);
	cov_mrx_slot:    cover property (o_slot_done && op == ssb_pkg::OP_MRX);
	cov_mtx_slot:    cover property (o_slot_done && op == ssb_pkg::OP_MTX);
	cov_both_slot:   cover property (o_slot_done && op == ssb_pkg::OP_BOTH);
	cov_cut_slot:    cover property (state == ssb_pkg::ST_DATA && !selected);
endmodule

/* hdl/ssb_pkg.sv */
// Shared constants and types for the handshake SPI slave
// What this block does
// - Stay quiet until chip select goes low
// - Shift out and sample with master clock
// - Be ready before master clocks a transfer
// - Busy low means ready, high otherwise
// - Command plus transfer form 1 ms slots
// - No new command before transfer ends
// - Status reports sendable or free count
// - Receive command: slave sends characters
// - Transmit command: slave captures characters
// - Both command: send and capture together
// - Eight bits, MSB first, phase type 1
// - Nominal 1 Mbps, down to 200 kbps
// - At most 63 characters, default 32
// - Busy low once command prep done
// - Busy high once command byte arrives
// - Busy low again when data ready
// - Upper two bits opcode, lower six count
// - Status tag 01 send, 00 receive
// - Busy high at slot end, prepare next
// - Deselect stops engine and output driver
package ssb_pkg;
	localparam int         OP_HI           = 7;
	localparam int         OP_LO           = 6;
	localparam int         CNT_HI          = 5;
	localparam logic [5:0] CHAR_LIMIT_DFLT = 6'h20;
	localparam logic [5:0] ONE_CHAR        = 6'h01;
	localparam logic [5:0] NO_CHARS        = 6'h00;
	localparam logic [1:0] STATUS_TAG_SEND = 2'h1;
	localparam logic [1:0] STATUS_TAG_RECV = 2'h0;
	localparam logic [7:0] FILL_BYTE       = 8'h00;
	localparam logic [2:0] LAST_BIT        = 3'h7;

	typedef enum logic [1:0] {
		OP_STATUS = 2'b00,
		OP_MRX    = 2'b01,
		OP_MTX    = 2'b10,
		OP_BOTH   = 2'b11
	} ssb_op_t;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_PREP   = 3'b001,
		ST_CMD    = 3'b010,
		ST_DECODE = 3'b011,
		ST_DATA   = 3'b100,
		ST_DONE   = 3'b101
	} ssb_state_t;
endpackage

/* hdl/ssb_link.sv */
// Serial-clock domain shifter of the handshake SPI slave
module ssb_link (
	input  wire logic       i_sck,
	input  wire logic       i_cs_n,
	input  wire logic       i_sdi,
	input  wire logic [7:0] i_tx_word,
	output logic            o_sdo,
	output logic [7:0]      o_rx_word,
	output logic            o_rx_toggle
);
	logic [2:0] bit_cnt;
	logic [2:0] next_bit_cnt;
	logic [6:0] shift;
	logic [6:0] next_shift;
	logic [7:0] next_rx_word;
	logic       next_rx_toggle;
	logic       next_sdo;

	// Sample on the rising edge; a full character flips the toggle
	always_comb begin
		next_bit_cnt   = bit_cnt + 3'h1;
		next_shift     = {shift[5:0], i_sdi};
		next_rx_word   = o_rx_word;
		next_rx_toggle = o_rx_toggle;
		if (bit_cnt == ssb_pkg::LAST_BIT) begin
			next_rx_word   = {shift, i_sdi};
			next_rx_toggle = ~o_rx_toggle;
		end
	end

	// Chip select high holds the engine cleared; the clock may stand still then
	always_ff @(posedge i_sck or posedge i_cs_n) begin
		if (i_cs_n) begin
			bit_cnt     <= 3'h0;
			shift       <= 7'h00;
			o_rx_word   <= 8'h00;
			o_rx_toggle <= 1'h0;
		end else begin
			bit_cnt     <= next_bit_cnt;
			shift       <= next_shift;
			o_rx_word   <= next_rx_word;
			o_rx_toggle <= next_rx_toggle;
		end
	end

	// MSB first on falling edges; the word is held steady by the busy handshake
	assign next_sdo = i_tx_word[~bit_cnt];

	always_ff @(negedge i_sck or posedge i_cs_n) begin
		if (i_cs_n) begin
			o_sdo <= 1'h0;
		end else begin
			o_sdo <= next_sdo;
		end
	end
endmodule

/* tb/ssb_spi_master.sv */
// Behavioural SPI master that polls the busy line between slot phases
module ssb_spi_master (
	output logic      o_sck,
	output logic      o_cs_n,
	output logic      o_mosi,
	input  wire logic i_miso,
	input  wire logic i_busy
);
	timeunit 1ns;
	timeprecision 100ps;

	// Idle high clock; select rises after time zero so the shifter sees a clearing edge
	initial begin
		o_sck = 1'b1;
		o_mosi = 1'b0;
		#1;
		o_cs_n = 1'b1;
	end

	// Poll in 1 ns steps so a short busy pulse is not missed; bounded wait never stalls
	task automatic wait_level(input logic lvl, input int lim, output logic ok);
		int t;
		ok = 1'b0;
		for (t = 0; t < lim && !ok; t++) begin
			if (i_busy === lvl) ok = 1'b1;
			else #1;
		end
	endtask

	// Type 1: drive on falling edge, sample on rising, MSB first, 12 ns period
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int b = 7; b >= 0; b--) begin
			o_sck = 1'b0;
			o_mosi = tx[b];
			#6;
			rx[b] = i_miso;
			o_sck = 1'b1;
			#6;
		end
		o_mosi = ~o_mosi;  // Stale data never lingers on the line
	endtask

	// One slot: command byte, then n characters (possibly fewer than the command's count) before deselect
	task automatic slot(input logic [7:0] cmd, input int n, input logic [7:0] tq[$],
		output logic [7:0] rq[$], output logic [3:0] ok);
		logic [7:0] r;
		rq = {};
		ok = 4'h0;
		o_cs_n = 1'b0;
		wait_level(1'b0, 16000, ok[3]);
		// A timed-out wait abandons the slot rather than clocking a busy slave
		if (ok[3]) begin
			xfer(cmd, r);
			wait_level(1'b1, 100, ok[2]);
			ok[1] = 1'b1;
			if (n > 0) wait_level(1'b0, 16000, ok[1]);
		end
		for (int i = 0; i < n && ok[1]; i++) begin
			#200;  // Gap lets the slave reload its word
			xfer(tq[i], r);
			rq.push_back(r);
		end
		wait_level(1'b1, 200, ok[0]);
		o_cs_n = 1'b1;
		#100;
	endtask
endmodule

/* tb/tb_ssb_slave.sv */
// Self-checking bench for the handshake SPI slave
module tb_ssb_slave;
	timeunit 1ns;
	timeprecision 100ps;

	logic       i_sys_clk  = 1'b0;
	logic       i_sys_rst  = 1'b1;
	logic [5:0] char_limit = 6'h00;
	logic [5:0] tx_count   = 6'h00;
	logic [5:0] rx_space   = 6'h00;
	logic [7:0] tx_data    = 8'h00;
	logic       tx_valid   = 1'b1;
	logic       sck, cs_n, mosi, sdo, sdo_oe_n, busy_pin, busy_oe_n;
	logic       tx_take, rx_valid, slot_done;
	logic [7:0] rx_data;
	logic [1:0] slot_op;
	logic [7:0] sent_q[$], got_q[$];
	int         n_errors, comparisons, n_done;
	wire        busy_w = busy_oe_n ? 1'b1 : busy_pin;  // Pull-up when released
	wire        miso_w = sdo_oe_n ? ~sdo : sdo;

	always #5 i_sys_clk = ~i_sys_clk;

	ssb_slave u_ssb_slave (
		.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
		.i_slave_serial_clock_in(sck), .i_select_sense_pin_n(cs_n),
		.i_slave_serial_data_in(mosi), .o_slave_serial_data_out(sdo),
		.o_slave_serial_data_out_oe_n(sdo_oe_n), .o_busy_handshake_pin(busy_pin),
		.o_busy_handshake_pin_oe_n(busy_oe_n), .i_char_limit(char_limit),
		.i_tx_count(tx_count), .i_rx_space(rx_space), .i_tx_data(tx_data),
		.i_tx_valid(tx_valid), .o_tx_take(tx_take), .o_rx_data(rx_data),
		.o_rx_valid(rx_valid), .o_slot_op(slot_op), .o_slot_done(slot_done)
	);

	ssb_spi_master u_ssb_spi_master (
		.o_sck(sck), .o_cs_n(cs_n), .o_mosi(mosi), .i_miso(miso_w), .i_busy(busy_w)
	);

	// Offer a fresh character after each take; log captures and slot ends
	always @(posedge i_sys_clk) begin
		if (tx_take === 1'b1) begin
			sent_q.push_back(tx_data);
			tx_data <= 8'($urandom);
		end
		if (rx_valid === 1'b1) got_q.push_back(rx_data);
		if (slot_done === 1'b1) n_done++;
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Zero limit means the default of 32
	function automatic logic [5:0] cap(input logic [5:0] n);
		logic [5:0] l;
		l = (char_limit == 6'h00) ? 6'h20 : char_limit;
		return (n > l) ? l : n;
	endfunction

	function automatic logic [7:0] stat_exp();
		if (tx_count != 6'h00) return {2'h1, cap(tx_count)};
		return {2'h0, cap(rx_space)};
	endfunction

	task automatic set_cfg(input logic [5:0] lim, input logic [5:0] txc, input logic [5:0] rxs,
		input logic vld);
		@(posedge i_sys_clk);
		tx_valid <= vld;
		char_limit <= lim;
		tx_count <= txc;
		rx_space <= rxs;
		@(posedge i_sys_clk);
	endtask

	// A cut below the full count deselects in mid transfer
	task automatic run_slot(input logic [1:0] op, input logic [5:0] cnt, input int cut);
		logic [7:0] mq[$], rq[$];
		logic [3:0] ok;
		int         n, full, d0, takes;
		if (op == 2'h0) cnt = 6'h00;
		full = (op == 2'h0) ? 1 : int'(cap(cnt));
		n = (cut >= 0) ? cut : full;
		for (int i = 0; i < n; i++) mq.push_back(8'($urandom));
		sent_q = {};
		got_q = {};
		d0 = n_done;
		check("busy_idle", busy_w, 1'b1);
		u_ssb_spi_master.slot({op, cnt}, n, mq, rq, ok);
		check("handshake", ok, {3'h7, n == full});
		repeat (2) @(posedge i_sys_clk);
		check("sdo_oe_n", sdo_oe_n, 1'b1);
		check("slot_op", slot_op, op);
		check("slot_done", n_done - d0, n == full);
		// One take per character sent; a cut slot has already preloaded one more
		takes = (op[0] && tx_valid && n > 0) ? n + int'(n < full) : 0;
		check("tx_takes", sent_q.size(), takes);
		for (int i = 0; i < n; i++) begin
			if (op == 2'h0) check("status", rq[i], stat_exp());
			if (op[0] && tx_valid) check("miso", rq[i], sent_q[i]);
			if (op[0] && !tx_valid) check("miso_fill", rq[i], ssb_pkg::FILL_BYTE);
			if (op[1]) check("mosi", got_q[i], mq[i]);
		end
		if (op[1]) check("rx_count", got_q.size(), n);
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Corner slots first, then random ones
	initial begin
		void'($urandom(32'h987c357a));
		repeat (16) @(posedge i_sys_clk);
		i_sys_rst <= 1'b0;
		repeat (3) @(posedge i_sys_clk);
		check("busy_rst", busy_w, 1'b1);
		check("oe_rst", sdo_oe_n, 1'b1);
		set_cfg(6'h00, 6'h00, 6'h2a, 1'b1);
		run_slot(2'h0, 6'h00, -1);
		set_cfg(6'h05, 6'h3f, 6'h01, 1'b1);
		run_slot(2'h0, 6'h00, -1);
		set_cfg(6'h3f, 6'h00, 6'h00, 1'b1);
		run_slot(2'h3, 6'h3f, -1);
		// Nothing offered by the user side: the slave must send fill bytes
		set_cfg(6'h00, 6'h00, 6'h00, 1'b0);
		run_slot(2'h3, 6'h05, -1);
		set_cfg(6'h00, 6'h00, 6'h00, 1'b1);
		run_slot(2'h1, 6'h3f, -1);
		run_slot(2'h2, 6'h00, -1);
		run_slot(2'h3, 6'h0a, 3);
		run_slot(2'h2, 6'h04, -1);
		for (int k = 0; k < 12; k++) begin
			set_cfg(6'($urandom_range(0, 40)), 6'($urandom_range(0, 3)), 6'($urandom),
				$urandom_range(0, 3) != 0);
			run_slot(2'($urandom), 6'($urandom_range(1, 40)), -1);
		end
		report_and_stop();
	end

	// Watchdog well beyond the expected run length
	initial begin
		#600000;
		n_errors++;
		report_and_stop();
	end
endmodule
